// ### gateway_pkg.sv
/*
   Shared constants of the switch, toggle and serial gateway logic.
   Assumes one 200 MHz system clock and a synchronous active high reset.
*/
package gateway_pkg;
   // Clock and serial link timing.
   localparam int CLK_HZ = 200_000_000;
   localparam int BAUD_RATE = 9600;
   localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;
   localparam int DATA_BITS = 8;
   localparam int STOP_INDEX = DATA_BITS + 1;
   localparam int SYNC_STAGES = 2;

   // Message framing bytes and payload size of one data set.
   localparam logic [7:0] STX_BYTE = 8'h02;
   localparam logic [7:0] CR_BYTE = 8'h0d;
   localparam logic [7:0] LF_BYTE = 8'h0a;
   localparam logic [2:0] PAYLOAD_BYTES = 3'h4;
   localparam logic [2:0] TX_LAST_INDEX = 3'h6;

   // Switch limits; the fieldbus itself would allow addresses up to 127.
   localparam logic [3:0] DIGIT_MAX = 4'h9;
   localparam logic [7:0] TENS_WEIGHT = 8'h0a;
   localparam logic [3:0] RATE_AUTO = 4'h0;
   localparam logic [3:0] RATE_MAX = 4'h9;
   localparam logic [3:0] DEV_PARAM_RESET = 4'hf;
   localparam logic [31:0] PARAM_DEFAULT = 32'h0000_0000;

   // Bit rate in kBd for switch positions 1 to 9; position 0 is automatic.
   localparam logic [10:0] RATE_KBD [0:9] = '{11'h000, 11'h00a, 11'h014, 11'h032,
      11'h064, 11'h07d, 11'h0fa, 11'h1f4, 11'h320, 11'h3e8};

   // Register offsets.
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_CONTROL = 8'h04;
   localparam logic [7:0] REG_OUT_DATA = 8'h08;
   localparam logic [7:0] REG_IN_DATA = 8'h0c;
   localparam logic [7:0] REG_SWITCHES = 8'h10;
   localparam logic [7:0] REG_NET_CFG = 8'h14;
   localparam logic [7:0] REG_PARAM = 8'h18;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h1c;
   localparam logic [7:0] REG_IRQ_MASK = 8'h20;

   // Field positions.
   localparam int ST_NEW_DATA = 0;
   localparam int ST_LINK_OK = 1;
   localparam int ST_TX_BUSY = 2;
   localparam int ST_CFG_READY = 3;
   localparam int ST_IN_LEN = 4;
   localparam int ST_PROFILE = 8;
   localparam int CTRL_SEND = 0;
   localparam int CTRL_SEEN = 1;
   localparam int SW_ADDR = 0;
   localparam int SW_ADDR_OK = 7;
   localparam int SW_RATE = 8;
   localparam int SW_RATE_OK = 12;
   localparam int SW_KBD = 16;
   localparam int SW_DEV = 28;
   localparam int NET_ADDR = 0;
   localparam int NET_RATE = 8;
   localparam int IRQ_NEW_DATA = 0;
   localparam int IRQ_TX_DONE = 1;
   localparam int IRQ_RX_ERROR = 2;
   localparam int IRQ_WIDTH = 3;
endpackage

// ### switch_sampler.sv
/*
   Synchronises the four rotary switches, captures them once after reset
   and decodes address, bit rate and device type.
   Assumes the switches are asynchronous pins that stay put while running.
*/
`timescale 1ns/100ps
module switch_sampler
   import gateway_pkg::*;
(
   // Clock, reset and enable.
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Switch pins.
   input wire logic [3:0] addr_ones_switch_i,
   input wire logic [3:0] addr_tens_switch_i,
   input wire logic [3:0] bitrate_switch_i,
   input wire logic [3:0] device_type_switch_i,
   // Decoded settings.
   output logic [6:0] node_addr_o,
   output logic addr_valid_o,
   output logic [3:0] rate_code_o,
   output logic rate_valid_o,
   output logic [10:0] rate_kbd_o,
   output logic [3:0] dev_type_o,
   output logic ready_o
);
   import gateway_pkg::*;

   typedef struct packed {
      logic [15:0] meta;
      logic [15:0] stable;
      logic [1:0] settle;
      logic ready;
      logic [15:0] snap;
   } sampler_state_type;

   sampler_state_type s_reg;
   sampler_state_type s_next;
   logic [7:0] addr_sum;

   ////////////////////////////////////////////////////////////////////////
   // Two stage synchroniser, then one capture once the pipeline is full.
   always_comb
   begin
      s_next = s_reg;
      s_next.meta = {device_type_switch_i, bitrate_switch_i, addr_tens_switch_i,
         addr_ones_switch_i};
      s_next.stable = s_reg.meta;
      if (!s_reg.ready)
      begin
         if (s_reg.settle == 2'(SYNC_STAGES))
         begin
            s_next.snap = s_reg.stable;
            s_next.ready = 1'b1;
         end
         else
         begin
            s_next.settle = s_reg.settle + 2'h1;
         end
      end
   end

   // Synchronous reset; the capture happens only after its release.
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         s_reg <= '0;
      else if (ce_i)
         s_reg <= s_next;
   end

   ////////////////////////////////////////////////////////////////////////
   // two decimal digits
   assign addr_sum = s_reg.snap[7:4] * TENS_WEIGHT + {4'h0, s_reg.snap[3:0]};
   assign node_addr_o = addr_sum[6:0];
   assign addr_valid_o = (s_reg.snap[3:0] <= DIGIT_MAX) && (s_reg.snap[7:4] <= DIGIT_MAX);
   assign rate_code_o = s_reg.snap[11:8];
   assign rate_valid_o = s_reg.snap[11:8] <= RATE_MAX;
   assign rate_kbd_o = rate_valid_o ? RATE_KBD[s_reg.snap[11:8]] : '0;
   assign dev_type_o = s_reg.snap[15:12];
   assign ready_o = s_reg.ready;
endmodule

// ### serial_byte_tx.sv
/*
   Serial transmitter, one start bit, eight data bits LSB first, one stop.
   Assumes the feeder holds its byte and valid until ready is seen high.
*/
`timescale 1ns/100ps
module serial_byte_tx
   import gateway_pkg::*;
#(
   parameter int BIT_PERIOD = gateway_pkg::BIT_CYCLES
)
(
   // Clock, reset and enable.
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Byte handshake.
   input wire logic [7:0] byte_i,
   input wire logic valid_i,
   output logic ready_o,
   // Serial line.
   output logic txd_o
);
   import gateway_pkg::*;

   typedef struct packed {
      logic busy;
      logic [15:0] count;
      logic [3:0] bit_index;
      logic [8:0] shift;
      logic line;
   } tx_state_type;

   tx_state_type s_reg;
   tx_state_type s_next;

   // Reset state holds the line at its idle high level.
   localparam tx_state_type TX_REST = '{busy: 1'b0, count: '0, bit_index: '0, shift: '0,
      line: 1'b1};

   ////////////////////////////////////////////////////////////////////////
   // Line level is registered so the pin comes straight from a flip-flop.
   always_comb
   begin
      s_next = s_reg;
      if (!s_reg.busy)
      begin
         if (valid_i)
         begin
            s_next.busy = 1'b1;
            s_next.count = '0;
            s_next.bit_index = '0;
            s_next.shift = {1'b1, byte_i};
            s_next.line = 1'b0;
         end
      end
      else if (s_reg.count == 16'(BIT_PERIOD - 1))
      begin
         s_next.count = '0;
         if (s_reg.bit_index == 4'(STOP_INDEX))
         begin
            s_next.busy = 1'b0;
         end
         else
         begin
            s_next.line = s_reg.shift[0];
            s_next.shift = {1'b1, s_reg.shift[8:1]};
            s_next.bit_index = s_reg.bit_index + 4'h1;
         end
      end
      else
      begin
         s_next.count = s_reg.count + 16'h0001;
      end
   end

   // State register.
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         s_reg <= TX_REST;
      else if (ce_i)
         s_reg <= s_next;
   end

   assign ready_o = ~s_reg.busy;
   assign txd_o = s_reg.line;
endmodule

// ### gateway_switch_config_toggle.sv
/*
   Gateway core: switch configuration, toggle bit handshake with the
   controller, framing of serial messages to and from the attached reader,
   stored parameters and interrupt logic behind a plain register port.
   Assumes received serial bytes arrive from a receiver on this clock as
   one-cycle strobes, and that software drives the register port.
*/
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps

// Behaviour
// - bit and byte zero are least significant
// - flip new-data toggle per delivered set
// - send toggle change takes output data
// - pass online commands through unchanged
// - address from ones and tens digits
// - decode bit rate switch positions
// - communicate only with matching bit rate; switch position 0 (automatic) links at any controller rate
// - communicate only with matching node address
// - device switch sets profile at start
// - keep parameters downloaded by controller
// - move data sets whole and ordered
// - serial 9600 8N1, STX data CR LF
module gateway_switch_config_toggle
   import gateway_pkg::*;
#(
   parameter int BIT_PERIOD = gateway_pkg::BIT_CYCLES
)
(
   // Clock, reset and enable.
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Register port.
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // Rotary switch pins.
   input wire logic [3:0] addr_ones_switch_i,
   input wire logic [3:0] addr_tens_switch_i,
   input wire logic [3:0] bitrate_switch_i,
   input wire logic [3:0] device_type_switch_i,
   // Serial side of the attached reader.
   input wire logic [7:0] rx_byte_i,
   input wire logic rx_valid_i,
   output logic txd_o,
   // Fieldbus side indications.
   output logic new_data_toggle_o,
   output logic link_ok_o,
   output logic [6:0] node_addr_o,
   output logic irq_o
);
   import gateway_pkg::*;

   typedef enum logic [1:0] {RX_HUNT, RX_DATA, RX_LF} rx_state_type;
   typedef enum logic {TX_IDLE, TX_SEND} tx_phase_type;

   typedef struct packed {
      logic [31:0] rdata;
      logic send_toggle;
      logic send_seen;
      logic [31:0] out_word;
      logic [31:0] tx_word;
      logic [2:0] tx_index;
      tx_phase_type tx_phase;
      rx_state_type rx_state;
      logic [31:0] rx_buf;
      logic [2:0] rx_count;
      logic rx_overflow;
      logic [31:0] in_word;
      logic [2:0] in_len;
      logic new_data_toggle;
      logic [6:0] net_addr;
      logic [3:0] net_rate;
      logic [31:0] param;
      logic [3:0] profile;
      logic profile_set;
      logic [IRQ_WIDTH-1:0] irq_status;
      logic [IRQ_WIDTH-1:0] irq_mask;
      logic irq;
      logic link_ok;
      logic [6:0] node_addr;
   } gateway_state_type;

   gateway_state_type s_reg;
   gateway_state_type s_next;

   logic [6:0] sw_addr;
   logic sw_addr_ok;
   logic [3:0] sw_rate;
   logic sw_rate_ok;
   logic [10:0] sw_kbd;
   logic [3:0] sw_dev;
   logic sw_ready;
   logic [7:0] tx_byte;
   logic tx_valid;
   logic tx_ready;
   logic link_match;
   logic [IRQ_WIDTH-1:0] irq_event;
   logic [IRQ_WIDTH-1:0] irq_clear;
   logic [31:0] read_value;

   ////////////////////////////////////////////////////////////////////////
   // Switch capture and serial transmitter.
   switch_sampler switches
   (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .addr_ones_switch_i(addr_ones_switch_i),
      .addr_tens_switch_i(addr_tens_switch_i),
      .bitrate_switch_i(bitrate_switch_i),
      .device_type_switch_i(device_type_switch_i),
      .node_addr_o(sw_addr),
      .addr_valid_o(sw_addr_ok),
      .rate_code_o(sw_rate),
      .rate_valid_o(sw_rate_ok),
      .rate_kbd_o(sw_kbd),
      .dev_type_o(sw_dev),
      .ready_o(sw_ready)
   );

   serial_byte_tx #(.BIT_PERIOD(BIT_PERIOD)) transmitter
   (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .byte_i(tx_byte),
      .valid_i(tx_valid),
      .ready_o(tx_ready),
      .txd_o(txd_o)
   );

   ////////////////////////////////////////////////////////////////////////
   // Link admission: settings must agree with the controller's view.
   always_comb
   begin
      link_match = sw_ready && sw_addr_ok && sw_rate_ok;
      if (sw_addr != s_reg.net_addr)
         link_match = 1'b0;
      if ((sw_rate != RATE_AUTO) && (sw_rate != s_reg.net_rate))
         link_match = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Outgoing frame byte: STX, the four data bytes from byte 0 up, CR, LF.
   always_comb
   begin
      tx_valid = (s_reg.tx_phase == TX_SEND);
      case (s_reg.tx_index)
         3'h0: tx_byte = STX_BYTE;
         3'h5: tx_byte = CR_BYTE;
         3'h6: tx_byte = LF_BYTE;
         default: tx_byte = s_reg.tx_word[{s_reg.tx_index[1:0] - 2'h1, 3'h0} +: 8];
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Register read multiplexer; unmapped offsets read as zero.
   always_comb
   begin
      read_value = '0;
      case (reg_addr_i)
         REG_STATUS:
         begin
            read_value[ST_NEW_DATA] = s_reg.new_data_toggle;
            read_value[ST_LINK_OK] = s_reg.link_ok;
            read_value[ST_TX_BUSY] = (s_reg.tx_phase == TX_SEND);
            read_value[ST_CFG_READY] = sw_ready;
            read_value[ST_IN_LEN +: 3] = s_reg.in_len;
            read_value[ST_PROFILE +: 4] = s_reg.profile;
         end
         REG_CONTROL:
         begin
            read_value[CTRL_SEND] = s_reg.send_toggle;
            read_value[CTRL_SEEN] = s_reg.send_seen;
         end
         REG_OUT_DATA: read_value = s_reg.out_word;
         REG_IN_DATA: read_value = s_reg.in_word;
         REG_SWITCHES:
         begin
            read_value[SW_ADDR +: 7] = sw_addr;
            read_value[SW_ADDR_OK] = sw_addr_ok;
            read_value[SW_RATE +: 4] = sw_rate;
            read_value[SW_RATE_OK] = sw_rate_ok;
            read_value[SW_KBD +: 11] = sw_kbd;
            read_value[SW_DEV +: 4] = sw_dev;
         end
         REG_NET_CFG:
         begin
            read_value[NET_ADDR +: 7] = s_reg.net_addr;
            read_value[NET_RATE +: 4] = s_reg.net_rate;
         end
         REG_PARAM: read_value = s_reg.param;
         REG_IRQ_STATUS: read_value[IRQ_WIDTH-1:0] = s_reg.irq_status;
         REG_IRQ_MASK: read_value[IRQ_WIDTH-1:0] = s_reg.irq_mask;
         default: read_value = '0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state of the whole block.
   always_comb
   begin
      s_next = s_reg;
      irq_event = '0;
      irq_clear = '0;
      s_next.link_ok = link_match;
      s_next.node_addr = sw_addr;

      // Read data stand for one cycle only, zero otherwise.
      s_next.rdata = reg_rd_i ? read_value : '0;

      // Register writes.
      if (reg_wr_i)
      begin
         case (reg_addr_i)
            REG_CONTROL: s_next.send_toggle = reg_wdata_i[CTRL_SEND];
            REG_OUT_DATA: s_next.out_word = reg_wdata_i;
            REG_NET_CFG:
            begin
               s_next.net_addr = reg_wdata_i[NET_ADDR +: 7];
               s_next.net_rate = reg_wdata_i[NET_RATE +: 4];
            end
            REG_PARAM: s_next.param = reg_wdata_i;
            REG_IRQ_STATUS: irq_clear = reg_wdata_i[IRQ_WIDTH-1:0];
            REG_IRQ_MASK: s_next.irq_mask = reg_wdata_i[IRQ_WIDTH-1:0];
            default: s_next.rdata = s_next.rdata;
         endcase
      end

      // Device profile is fixed once when the switches are first valid;
      // the parameter reset position restores the defaults at that moment.
      if (sw_ready && !s_reg.profile_set)
      begin
         s_next.profile = sw_dev;
         s_next.profile_set = 1'b1;
         if (sw_dev == DEV_PARAM_RESET)
            s_next.param = PARAM_DEFAULT;
      end

      // Transmit sequencer. A toggle that flips twice while a frame is
      // still going out is seen as no change: the controller must wait.
      case (s_reg.tx_phase)
         TX_IDLE:
         begin
            if (s_reg.link_ok && (s_reg.send_toggle != s_reg.send_seen))
            begin
               s_next.send_seen = s_reg.send_toggle;
               s_next.tx_word = s_reg.out_word;
               s_next.tx_index = '0;
               s_next.tx_phase = TX_SEND;
            end
         end
         TX_SEND:
         begin
            if (tx_ready)
            begin
               if (s_reg.tx_index == TX_LAST_INDEX)
               begin
                  s_next.tx_phase = TX_IDLE;
                  irq_event[IRQ_TX_DONE] = 1'b1;
               end
               else
               begin
                  s_next.tx_index = s_reg.tx_index + 3'h1;
               end
            end
         end
         default: s_next.tx_phase = TX_IDLE;
      endcase

      // Receive framer: a set is only delivered whole, never cut short.
      if (rx_valid_i)
      begin
         case (s_reg.rx_state)
            RX_HUNT:
            begin
               if (rx_byte_i == STX_BYTE)
               begin
                  s_next.rx_state = RX_DATA;
                  s_next.rx_count = '0;
                  s_next.rx_overflow = 1'b0;
                  s_next.rx_buf = '0;
               end
            end
            RX_DATA:
            begin
               if (rx_byte_i == CR_BYTE)
               begin
                  s_next.rx_state = RX_LF;
               end
               else if (rx_byte_i == STX_BYTE)
               begin
                  s_next.rx_count = '0;
                  s_next.rx_overflow = 1'b0;
                  s_next.rx_buf = '0;
               end
               else if (s_reg.rx_count == PAYLOAD_BYTES)
               begin
                  s_next.rx_overflow = 1'b1;
               end
               else
               begin
                  // first byte lands in byte 0
                  s_next.rx_buf[{s_reg.rx_count[1:0], 3'h0} +: 8] = rx_byte_i;
                  s_next.rx_count = s_reg.rx_count + 3'h1;
               end
            end
            RX_LF:
            begin
               s_next.rx_state = RX_HUNT;
               if ((rx_byte_i != LF_BYTE) || s_reg.rx_overflow ||
                  (s_reg.rx_count == '0) || !s_reg.link_ok)
               begin
                  irq_event[IRQ_RX_ERROR] = 1'b1;
               end
               else
               begin
                  s_next.in_word = s_reg.rx_buf;
                  s_next.in_len = s_reg.rx_count;
                  s_next.new_data_toggle = ~s_reg.new_data_toggle;
                  irq_event[IRQ_NEW_DATA] = 1'b1;
               end
            end
            default: s_next.rx_state = RX_HUNT;
         endcase
      end

      // Sticky status: a new event wins over a clear in the same cycle.
      s_next.irq_status = (s_reg.irq_status & ~irq_clear) | irq_event;
      s_next.irq = |(s_next.irq_status & s_next.irq_mask);
   end

   ////////////////////////////////////////////////////////////////////////
   // State register; enable low freezes everything.
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         s_reg <= '0;
      else if (ce_i)
         s_reg <= s_next;
   end

   // Outputs come straight from the state register.
   assign reg_rdata_o = s_reg.rdata;
   assign new_data_toggle_o = s_reg.new_data_toggle;
   assign link_ok_o = s_reg.link_ok;
   assign node_addr_o = s_reg.node_addr;
   assign irq_o = s_reg.irq;
endmodule

// ### gateway_chk.sv
/*
   Port checker of the gateway core.
   Assumes it is bound to the core and sees only its ports.
*/
`timescale 1ns/100ps
module gateway_chk
   import gateway_pkg::*;
#(
   parameter int BIT_PERIOD = 8
)
(
   // Clock and reset.
   input wire logic clock_i,
   input wire logic rst_i,
   // Register port.
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   // Serial and fieldbus side.
   input wire logic [7:0] rx_byte_i,
   input wire logic rx_valid_i,
   input wire logic txd_o,
   input wire logic new_data_toggle_o,
   input wire logic link_ok_o,
   input wire logic [6:0] node_addr_o,
   input wire logic irq_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   logic [15:0] low_cnt;
   logic [15:0] hi_cnt;
   logic [4:0] age;
   logic send_bit;
   logic [2:0] mask_sh;
   // Line run lengths and shadows of the last control and mask writes.
   always_ff @(posedge clock_i)
   begin
      low_cnt <= txd_o ? 16'h0000 : low_cnt + 16'h0001;
      hi_cnt <= (!txd_o || rst_i) ? 16'h0000 : hi_cnt + 16'(hi_cnt != 16'hffff);
      age <= rst_i ? 5'h00 : age + 5'(age != 5'h1f);
      if (rst_i || (reg_wr_i && reg_addr_i == REG_CONTROL))
         send_bit <= !rst_i && reg_wdata_i[CTRL_SEND];
      if (rst_i || (reg_wr_i && reg_addr_i == REG_IRQ_MASK))
         mask_sh <= rst_i ? 3'h0 : reg_wdata_i[2:0];
   end
   // A flipped send bit on a quiet, linked line is a request.
   sequence send_req;
      reg_wr_i && reg_addr_i == REG_CONTROL && reg_wdata_i[CTRL_SEND] != send_bit
         && link_ok_o && hi_cnt > 16'(12 * BIT_PERIOD);
   endsequence
   sequence start_bit;
      ##[2:4] !txd_o;
   endsequence
   a_send_start: assert property (send_req |-> start_bit)
      else $error("send toggle did not start a frame");
   a_toggle_cause: assert property ($changed(new_data_toggle_o) |->
      $past(rx_valid_i && rx_byte_i == LF_BYTE && link_ok_o))
      else $error("new data toggle moved without a closed set");
   a_bit_width: assert property ($rose(txd_o) |->
      low_cnt != 16'h0000 && low_cnt % 16'(BIT_PERIOD) == 16'h0000)
      else $error("low run not whole bit times");
   a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000)
      else $error("read data outside read cycle");
   a_addr_range: assert property (node_addr_o <= 7'h63)
      else $error("node address above 99");
   a_addr_hold: assert property (age == 5'h1f |-> $stable(node_addr_o))
      else $error("node address changed after capture");
   a_irq_masked: assert property (irq_o |-> mask_sh != 3'h0)
      else $error("interrupt with all sources masked");
   a_irq_drop: assert property (reg_wr_i && reg_addr_i == REG_IRQ_MASK &&
      reg_wdata_i[2:0] == 3'h0 |-> ##3 !irq_o)
      else $error("interrupt stayed after masking");
endmodule
bind gateway_switch_config_toggle gateway_chk #(.BIT_PERIOD(BIT_PERIOD)) u_chk (
   .clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .rx_byte_i(rx_byte_i), .rx_valid_i(rx_valid_i), .txd_o(txd_o),
   .new_data_toggle_o(new_data_toggle_o), .link_ok_o(link_ok_o),
   .node_addr_o(node_addr_o), .irq_o(irq_o));

// ### reader_model.sv
/*
   Model of the attached reader: decodes the serial line, sends bytes.
   Assumes it shares the core clock and bit period.
*/
`timescale 1ns/100ps
module reader_model
#(
   parameter int BIT_PERIOD = 8
)
(
   input wire logic clock_i,
   input wire logic txd_i,
   output logic [7:0] rx_byte_o,
   output logic rx_valid_o
);
   logic [7:0] got [$];
   logic [7:0] sh;
   initial
   begin
      rx_byte_o = 8'h00;
      rx_valid_o = 1'b0;
   end
   always
   begin
      @(negedge txd_i);
      repeat (BIT_PERIOD / 2) @(posedge clock_i);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BIT_PERIOD) @(posedge clock_i);
         sh[i] = txd_i;
      end
      repeat (BIT_PERIOD) @(posedge clock_i);
      // A byte with a broken stop bit is dropped, so the compare misses it.
      if (txd_i)
         got.push_back(sh);
   end
   // Strobe one byte, then show a changed value so stale data never matches.
   task automatic send(input logic [7:0] b);
      @(posedge clock_i);
      rx_byte_o <= b;
      rx_valid_o <= 1'b1;
      @(posedge clock_i);
      rx_valid_o <= 1'b0;
      rx_byte_o <= ~b;
   endtask
endmodule

// ### gateway_switch_config_toggle_tb.sv
/*
   Testbench of the gateway core with a reader model.
   Assumes a short bit period so frames stay brief.
*/
`timescale 1ns/100ps
module gateway_switch_config_toggle_tb;
   import gateway_pkg::*;
   logic clock_i, rst_i, reg_wr_i, reg_rd_i, rx_valid_i, txd_o, new_data, lk, irq_o;
   logic [7:0] reg_addr_i, rx_byte_i;
   logic [31:0] reg_wdata_i, reg_rdata_o;
   logic [3:0] ones, tens, rate;
   logic [6:0] node;
   int error_cnt = 0;
   int check_count = 0;
   logic [10:0] kbd [10] = '{11'h000, 11'h00a, 11'h014, 11'h032, 11'h064, 11'h07d,
      11'h0fa, 11'h1f4, 11'h320, 11'h3e8};
   logic [7:0] tx_exp [7] = '{8'h02, 8'h81, 8'h3c, 8'h5a, 8'h1b, 8'h0d, 8'h0a};
   gateway_switch_config_toggle #(.BIT_PERIOD(8)) u_dut (.clock_i(clock_i),
      .rst_i(rst_i), .ce_i(1'b1), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .addr_ones_switch_i(ones), .addr_tens_switch_i(tens), .bitrate_switch_i(rate),
      .device_type_switch_i(4'h2), .rx_byte_i(rx_byte_i), .rx_valid_i(rx_valid_i),
      .txd_o(txd_o), .new_data_toggle_o(new_data), .link_ok_o(lk), .node_addr_o(node),
      .irq_o(irq_o));
   reader_model #(.BIT_PERIOD(8)) u_rdr (.clock_i(clock_i), .txd_i(txd_o),
      .rx_byte_o(rx_byte_i), .rx_valid_o(rx_valid_i));
   always #2.5 clock_i = ~clock_i;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
      repeat (3) @(posedge clock_i);
   endtask
   // Read data stand only in the cycle after the strobe.
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      #1 check(reg_rdata_o, exp);
      @(posedge clock_i);
   endtask
   task automatic frame(input logic [7:0] n);
      u_rdr.send(STX_BYTE);
      for (int i = 0; i < n; i++)
         u_rdr.send(8'h41 + 8'(i));
      u_rdr.send(CR_BYTE);
      u_rdr.send(LF_BYTE);
      repeat (2) @(posedge clock_i);
   endtask
   task automatic conclude();
      $display("checks %0d, errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clock_i = 1'b0;
      {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
      {tens, ones} = 8'h43;
      for (int p = 0; p < 10; p++)
      begin
         rate <= 4'(p);
         rst_i <= 1'b1;
         repeat (6) @(posedge clock_i);
         rst_i <= 1'b0;
         repeat (8) @(posedge clock_i);
         rd(REG_SWITCHES, {4'h2, 1'b0, kbd[p], 4'h1, 4'(p), 8'hab});
      end
      rd(REG_STATUS, 32'h0000_0208);
      ones <= 4'h7;
      repeat (8) @(posedge clock_i);
      check({25'h0, node}, 32'h0000_002b);
      frame(1);
      check({31'h0, new_data}, 32'h0000_0000);
      rd(REG_IRQ_STATUS, 32'h0000_0004);
      wr(REG_IRQ_STATUS, 32'h0000_0004);
      wr(REG_NET_CFG, 32'h0000_092a);
      check({31'h0, lk}, 32'h0000_0000);
      wr(REG_NET_CFG, 32'h0000_082b);
      check({31'h0, lk}, 32'h0000_0000);
      wr(REG_NET_CFG, 32'h0000_092b);
      check({31'h0, lk}, 32'h0000_0001);
      wr(REG_IRQ_MASK, 32'h0000_0007);
      frame(4);
      check({30'h0, new_data, irq_o}, 32'h0000_0003);
      rd(REG_IN_DATA, 32'h4443_4241);
      rd(REG_STATUS, 32'h0000_024b);
      wr(REG_IRQ_STATUS, 32'h0000_0001);
      check({31'h0, irq_o}, 32'h0000_0000);
      frame(5);
      rd(REG_IRQ_STATUS, 32'h0000_0004);
      wr(REG_IRQ_MASK, 32'h0000_0000);
      check({30'h0, new_data, irq_o}, 32'h0000_0002);
      wr(REG_IN_DATA, 32'h0000_0000);
      rd(REG_IN_DATA, 32'h4443_4241);
      wr(REG_IRQ_STATUS, 32'h0000_0007);
      wr(REG_OUT_DATA, 32'h1b5a_3c81);
      wr(REG_CONTROL, 32'h0000_0001);
      for (int t = 0; t < 2000 && u_rdr.got.size() < 7; t++)
         @(posedge clock_i);
      // A frame that never completes counts as one mismatch on top of the failed compares of its missing bytes.
      if (u_rdr.got.size() < 7)
         error_cnt++;
      for (int i = 0; i < 7; i++)
         check({24'h0, u_rdr.got[i]}, {24'h0, tx_exp[i]});
      rd(REG_IRQ_STATUS, 32'h0000_0002);
      rd(REG_CONTROL, 32'h0000_0003);
      wr(REG_PARAM, 32'ha5c3_3c5a);
      rd(REG_PARAM, 32'ha5c3_3c5a);
      rd(8'h3c, 32'h0000_0000);
      conclude();
   end
endmodule
